// >>> verilog/exec_unit.v
// execute unit for loads, stores, program memory, I/O, stack, shifts, bit and flag ops
// assumes issue only while ready_o is high; memories answer combinationally
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "core_exec_map.vh"

module exec_unit (
    input wire mclk_i, // core clock
    input wire resetn_i, // async reset, low active
    input wire issue_i, // instruction offered
    input wire [4:0] op_i, // operation code
    input wire [2:0] sub_i, // pointer, shift, bit or flag select
    input wire [15:0] imm_i, // address or offset
    input wire [7:0] rr_i, // source register value
    input wire [4:0] rd_idx_i, // destination register index
    input wire [15:0] ptr_x_i, // first pointer pair
    input wire [15:0] ptr_y_i, // second pointer pair
    input wire [15:0] ptr_z_i, // third pointer pair
    input wire [15:0] r10_i, // register pair one:zero
    input wire [15:0] sp_i, // stack pointer
    input wire [7:0] ext_i, // program_pointer_extension_byte
    input wire [7:0] dm_rdata_i, // data memory read data
    input wire dm_wait_i, // external memory stretch
    input wire [7:0] pm_rdata_i, // program memory byte
    input wire [7:0] io_rdata_i, // I/O read data
    output wire ready_o, // can take an op
    output reg [7:0] flags_o, // status_flags_register
    output reg rf_we_o, // register write pulse
    output reg [4:0] rf_idx_o, // register index
    output reg [7:0] rf_wdata_o, // register data
    output reg ptr_we_o, // pointer update pulse
    output reg [1:0] ptr_sel_o, // which pointer
    output reg [15:0] ptr_wdata_o, // new pointer value
    output reg sp_we_o, // stack pointer write
    output reg [15:0] sp_wdata_o, // new stack pointer
    output reg dm_re_o, // data memory read
    output reg dm_we_o, // data memory write
    output reg [15:0] dm_addr_o, // data memory address
    output reg [7:0] dm_wdata_o, // data memory write data
    output reg pm_re_o, // program memory read
    output reg pm_we_o, // program word write
    output reg [23:0] pm_addr_o, // program byte address
    output reg [15:0] pm_wdata_o, // program word
    output reg io_re_o, // I/O read
    output reg io_we_o, // I/O write
    output reg [5:0] io_addr_o, // I/O address
    output reg [7:0] io_wdata_o, // I/O write data
    output reg break_o, // debug break pulse
    output reg sleep_o, // sleep request pulse
    output reg wdog_o // watchdog restart pulse
);
    // ============================================================
    // state
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [1:0] state_q;
    reg [2:0] cnt_q;
    reg [4:0] op_q;
    reg [4:0] idx_q;
    reg [15:0] addr_q;
    reg [23:0] paddr_q;
    reg [2:0] bit_q;
    reg data_q;

    wire [7:0] sh_res;
    wire [7:0] sh_flags;

    // ============================================================
    // helpers
    function [15:0] pick_ptr;
        input [1:0] sel;
        input [15:0] x;
        input [15:0] y;
        input [15:0] z;
        begin
            case (sel)
                2'h0: pick_ptr = x;
                2'h1: pick_ptr = y;
                default: pick_ptr = z;
            endcase
        end
    endfunction

    function in_sram;
        input [15:0] a;
        begin
            in_sram = (a >= `SRAM_BASE) && (a <= `SRAM_TOP);
        end
    endfunction

    shift_unit u_shift (
        .sub_i(sub_i),
        .val_i(rr_i),
        .carry_i(flags_o[`FLAG_C]),
        .flags_i(flags_o),
        .res_o(sh_res),
        .flags_o(sh_flags)
    );

    assign ready_o = (state_q == ST_IDLE);

    // ============================================================
    // issue and sequencing
    wire [15:0] ptr = pick_ptr(sub_i[1:0], ptr_x_i, ptr_y_i, ptr_z_i);
    wire [15:0] ptr_dec = ptr - 16'h0001;
    wire [15:0] ptr_inc = ptr + 16'h0001;
    wire [15:0] ptr_disp = ptr + imm_i;
    wire take = issue_i && ready_o;

    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            op_q <= `OP_NOP;
            idx_q <= 5'h00;
            addr_q <= `PTR_RESET;
            paddr_q <= 24'h0;
            bit_q <= 3'h0;
            data_q <= 1'b0;
            flags_o <= `FLAGS_RESET;
            rf_we_o <= 1'b0;
            rf_idx_o <= 5'h00;
            rf_wdata_o <= 8'h00;
            ptr_we_o <= 1'b0;
            ptr_sel_o <= 2'h0;
            ptr_wdata_o <= `PTR_RESET;
            sp_we_o <= 1'b0;
            sp_wdata_o <= `PTR_RESET;
            dm_re_o <= 1'b0;
            dm_we_o <= 1'b0;
            dm_addr_o <= `PTR_RESET;
            dm_wdata_o <= 8'h00;
            pm_re_o <= 1'b0;
            pm_we_o <= 1'b0;
            pm_addr_o <= 24'h0;
            pm_wdata_o <= 16'h0;
            io_re_o <= 1'b0;
            io_we_o <= 1'b0;
            io_addr_o <= 6'h00;
            io_wdata_o <= 8'h00;
            break_o <= 1'b0;
            sleep_o <= 1'b0;
            wdog_o <= 1'b0;
        end else begin
            rf_we_o <= 1'b0;
            ptr_we_o <= 1'b0;
            sp_we_o <= 1'b0;
            dm_re_o <= 1'b0;
            dm_we_o <= 1'b0;
            pm_re_o <= 1'b0;
            pm_we_o <= 1'b0;
            io_re_o <= 1'b0;
            io_we_o <= 1'b0;
            break_o <= 1'b0;
            sleep_o <= 1'b0;
            wdog_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        op_q <= op_i;
                        idx_q <= rd_idx_i;
                        bit_q <= sub_i;
                        rf_idx_o <= rd_idx_i;
                        ptr_sel_o <= sub_i[1:0];
                        case (op_i)
                            `OP_LD, `OP_LD_INC, `OP_ST, `OP_ST_INC: begin
                                addr_q <= ptr;
                                cnt_q <= `CYC_ONE + {2'h0, in_sram(ptr)};
                                if (op_i == `OP_LD_INC || op_i == `OP_ST_INC) begin
                                    ptr_we_o <= 1'b1;
                                    ptr_wdata_o <= ptr_inc;
                                end
                                state_q <= ST_WAIT;
                            end
                            `OP_LD_DEC, `OP_ST_DEC: begin
                                // pointer written first; access uses it
                                addr_q <= ptr_dec;
                                ptr_we_o <= 1'b1;
                                ptr_wdata_o <= ptr_dec;
                                cnt_q <= `CYC_TWO + {2'h0, in_sram(ptr_dec)};
                                state_q <= ST_WAIT;
                            end
                            `OP_LD_DISP, `OP_ST_DISP: begin
                                addr_q <= ptr_disp;
                                cnt_q <= `CYC_TWO + {2'h0, in_sram(ptr_disp)};
                                state_q <= ST_WAIT;
                            end
                            `OP_ST_DIRECT: begin
                                addr_q <= imm_i;
                                cnt_q <= `CYC_TWO + {2'h0, in_sram(imm_i)};
                                state_q <= ST_WAIT;
                            end
                            `OP_PM_READ, `OP_PM_READ_I, `OP_XPM_READ, `OP_XPM_READ_I: begin
                                // plain form reads the low page only
                                paddr_q <= (op_i == `OP_XPM_READ || op_i == `OP_XPM_READ_I) ?
                                    {ext_i, ptr_z_i} : {8'h00, ptr_z_i};
                                ptr_sel_o <= 2'h2;
                                if (op_i == `OP_PM_READ_I || op_i == `OP_XPM_READ_I) begin
                                    ptr_we_o <= 1'b1;
                                    ptr_wdata_o <= ptr_z_i + 16'h0001;
                                end
                                cnt_q <= `CYC_THREE;
                                state_q <= ST_WAIT;
                            end
                            `OP_PM_WRITE, `OP_PM_WRITE_I: begin
                                pm_we_o <= 1'b1;
                                pm_addr_o <= {ext_i, ptr_z_i};
                                pm_wdata_o <= r10_i;
                                ptr_sel_o <= 2'h2;
                                if (op_i == `OP_PM_WRITE_I) begin
                                    ptr_we_o <= 1'b1;
                                    ptr_wdata_o <= ptr_z_i + 16'h0002;
                                end
                            end
                            `OP_IO_IN: begin
                                io_re_o <= 1'b1;
                                io_addr_o <= imm_i[5:0];
                                rf_we_o <= 1'b1;
                                rf_wdata_o <= io_rdata_i;
                            end
                            `OP_IO_OUT: begin
                                io_we_o <= 1'b1;
                                io_addr_o <= imm_i[5:0];
                                io_wdata_o <= rr_i;
                            end
                            `OP_IO_FLAG_SET_GENERIC, `OP_IO_FLAG_CLEAR_GENERIC: begin
                                // read-modify-write in one cycle
                                io_re_o <= 1'b1;
                                io_we_o <= 1'b1;
                                io_addr_o <= imm_i[5:0];
                                io_wdata_o <= (op_i == `OP_IO_FLAG_SET_GENERIC) ? (io_rdata_i | (8'h01 << sub_i)) :
                                    (io_rdata_i & ~(8'h01 << sub_i));
                            end
                            `OP_PUSH: begin
                                dm_we_o <= 1'b1;
                                dm_addr_o <= sp_i;
                                dm_wdata_o <= rr_i;
                                sp_we_o <= 1'b1;
                                sp_wdata_o <= sp_i - 16'h0001;
                            end
                            `OP_POP: begin
                                addr_q <= sp_i + 16'h0001;
                                sp_we_o <= 1'b1;
                                sp_wdata_o <= sp_i + 16'h0001;
                                cnt_q <= `CYC_TWO;
                                state_q <= ST_WAIT;
                            end
                            `OP_SHIFT: begin
                                rf_we_o <= 1'b1;
                                rf_wdata_o <= sh_res;
                                flags_o <= sh_flags;
                            end
                            `OP_BIT_TO_T: begin
                                flags_o[`FLAG_T] <= rr_i[sub_i];
                            end
                            `OP_T_TO_BIT: begin
                                rf_we_o <= 1'b1;
                                rf_wdata_o <= flags_o[`FLAG_T] ? (rr_i | (8'h01 << sub_i)) :
                                    (rr_i & ~(8'h01 << sub_i));
                            end
                            `OP_FLAG_SET: begin
                                flags_o[sub_i] <= 1'b1;
                            end
                            `OP_FLAG_CLR: begin
                                flags_o[sub_i] <= 1'b0;
                            end
                            `OP_BREAK: begin
                                break_o <= 1'b1;
                            end
                            `OP_SLEEP: begin
                                sleep_o <= 1'b1;
                            end
                            `OP_WDOG: begin
                                wdog_o <= 1'b1;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_WAIT: begin
                    // access strobed on the last count
                    if (cnt_q > `CYC_ONE) begin
                        cnt_q <= cnt_q - 3'h1;
                    end else begin
                        state_q <= ST_DONE;
                        case (op_q)
                            `OP_LD, `OP_LD_INC, `OP_LD_DEC, `OP_LD_DISP, `OP_POP: begin
                                dm_re_o <= 1'b1;
                                dm_addr_o <= addr_q;
                            end
                            `OP_PM_READ, `OP_PM_READ_I, `OP_XPM_READ, `OP_XPM_READ_I: begin
                                pm_re_o <= 1'b1;
                                pm_addr_o <= paddr_q;
                            end
                            default: begin
                                dm_we_o <= 1'b1;
                                dm_addr_o <= addr_q;
                                dm_wdata_o <= rr_i;
                            end
                        endcase
                    end
                end
                ST_DONE: begin
                    // external memory may stretch
                    if (!dm_wait_i || pm_re_o) begin
                        state_q <= ST_IDLE;
                        if (pm_re_o) begin
                            rf_we_o <= 1'b1;
                            rf_idx_o <= idx_q;
                            rf_wdata_o <= pm_rdata_i;
                        end else if (dm_re_o) begin
                            rf_we_o <= 1'b1;
                            rf_idx_o <= idx_q;
                            rf_wdata_o <= dm_rdata_i;
                        end
                    end else begin
                        dm_re_o <= dm_re_o;
                        dm_we_o <= dm_we_o;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // exec_unit

// >>> pkg/core_exec_map.vh
// constants for the load/store and bit-operation execute unit
// assumes inclusion by bare name from the design files
`ifndef CORE_EXEC_MAP_VH
`define CORE_EXEC_MAP_VH

// operation codes presented on op_i
`define OP_NOP        5'h00
`define OP_LD         5'h01
`define OP_LD_INC     5'h02
`define OP_LD_DEC     5'h03
`define OP_LD_DISP    5'h04
`define OP_ST_DIRECT  5'h05
`define OP_ST         5'h06
`define OP_ST_INC     5'h07
`define OP_ST_DEC     5'h08
`define OP_ST_DISP    5'h09
`define OP_PM_READ    5'h0a
`define OP_PM_READ_I  5'h0b
`define OP_XPM_READ   5'h0c
`define OP_XPM_READ_I 5'h0d
`define OP_PM_WRITE   5'h0e
`define OP_PM_WRITE_I 5'h0f
`define OP_IO_IN      5'h10
`define OP_IO_OUT     5'h11
`define OP_PUSH       5'h12
`define OP_POP        5'h13
`define OP_SHIFT      5'h14
`define OP_IO_FLAG_SET_GENERIC    5'h15
`define OP_IO_FLAG_CLEAR_GENERIC    5'h16
`define OP_BIT_TO_T   5'h17
`define OP_T_TO_BIT   5'h18
`define OP_FLAG_SET   5'h19
`define OP_FLAG_CLR   5'h1a
`define OP_BREAK      5'h1b
`define OP_SLEEP      5'h1c
`define OP_WDOG       5'h1d

// shift sub-codes on sub_i
`define SH_LSL  3'h0
`define SH_LSR  3'h1
`define SH_ROL  3'h2
`define SH_ROR  3'h3
`define SH_ASR  3'h4
`define SH_SWAP 3'h5

// status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

`define FLAGS_RESET 8'h00
`define PTR_RESET   16'h0000
`define EXT_RESET   8'h00

// base cycle counts
`define CYC_ONE   3'h1
`define CYC_TWO   3'h2
`define CYC_THREE 3'h3

// internal static ram window in data space
`define SRAM_BASE 16'h2000
`define SRAM_TOP  16'h3fff

`endif

// >>> verilog/shift_unit.v
// combinational shift, rotate and nibble swap, with flag results for all but the swap
// assumes operand and carry come from the register file and flags
`timescale 1ns/1ps
`include "core_exec_map.vh"

module shift_unit (
    input wire [2:0] sub_i, // shift kind
    input wire [7:0] val_i, // operand
    input wire carry_i, // incoming carry
    input wire [7:0] flags_i, // current flags
    output reg [7:0] res_o, // result
    output reg [7:0] flags_o // updated flags
);
    reg c;
    always @* begin
        res_o = val_i;
        c = flags_i[`FLAG_C];
        flags_o = flags_i;
        case (sub_i)
            `SH_LSL: begin
                res_o = {val_i[6:0], 1'b0};
                c = val_i[7];
            end
            `SH_LSR: begin
                res_o = {1'b0, val_i[7:1]};
                c = val_i[0];
            end
            `SH_ROL: begin
                res_o = {val_i[6:0], carry_i};
                c = val_i[7];
            end
            `SH_ROR: begin
                res_o = {carry_i, val_i[7:1]};
                c = val_i[0];
            end
            `SH_ASR: begin
                res_o = {val_i[7], val_i[7:1]};
                c = val_i[0];
            end
            default: begin
                res_o = {val_i[3:0], val_i[7:4]};
            end
        endcase
        if (sub_i != `SH_SWAP) begin
            flags_o[`FLAG_C] = c;
            flags_o[`FLAG_Z] = (res_o == 8'h00);
            flags_o[`FLAG_N] = res_o[7];
            flags_o[`FLAG_V] = res_o[7] ^ c;
            flags_o[`FLAG_S] = res_o[7] ^ res_o[7] ^ c;
            // left shifts carry bit 3 out as half carry
            if (sub_i == `SH_LSL || sub_i == `SH_ROL) begin
                flags_o[`FLAG_H] = val_i[3];
            end
        end
    end
endmodule // shift_unit

// >>> sim/exec_unit_assertions.sv
// port-level checks on the execute unit
// assumes it is bound onto exec_unit; one clock, reset low active
`timescale 1ns/1ps
`include "core_exec_map.vh"
module exec_unit_assertions (
    input wire mclk_i, // clock
    input wire resetn_i, // reset
    input wire issue_i, // offer
    input wire [4:0] op_i, // op code
    input wire [2:0] sub_i, // sub code
    input wire [15:0] imm_i, // offset
    input wire [7:0] rr_i, // operand
    input wire [15:0] ptr_z_i, // third pointer
    input wire dm_wait_i, // stretch
    input wire ready_o, // idle
    input wire [7:0] flags_o, // flags
    input wire rf_we_o, // rf write
    input wire [7:0] rf_wdata_o, // rf data
    input wire ptr_we_o, // pointer write
    input wire [1:0] ptr_sel_o, // pointer select
    input wire [15:0] ptr_wdata_o // pointer data
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    wire take = issue_i && ready_o;
    wire sh = take && op_i == `OP_SHIFT;
    wire [15:0] za = ptr_z_i + imm_i;
    wire zin = za >= `SRAM_BASE && za <= `SRAM_TOP;
    wire ldz = take && op_i == `OP_LD_DISP && sub_i == 3'h2;
    // ==========================================
    // properties
    flags_keep_a: assert property (
        take && op_i inside {`OP_LD, `OP_ST, `OP_PUSH, `OP_POP, `OP_NOP, `OP_WDOG} |=> $stable(flags_o))
        else $error("flags moved");
    rol_result_a: assert property (
        sh && sub_i == `SH_ROL |=> rf_we_o && flags_o[0] == $past(rr_i[7])
        && rf_wdata_o == {$past(rr_i[6:0]), $past(flags_o[0])} && flags_o[1] == (rf_wdata_o == 8'h00)) else $error("rol");
    ror_result_a: assert property (
        sh && sub_i == `SH_ROR |=> rf_we_o && flags_o[0] == $past(rr_i[0])
        && rf_wdata_o == {$past(flags_o[0]), $past(rr_i[7:1])} && flags_o[2] == rf_wdata_o[7]) else $error("ror");
    flag_set_a: assert property (
        take && op_i == `OP_FLAG_SET |=> flags_o == ($past(flags_o) | (8'h01 << $past(sub_i)))) else $error("flag set");
    bit_store_a: assert property (
        take && op_i == `OP_BIT_TO_T |=> flags_o == {$past(flags_o[7]), $past(rr_i[sub_i]), $past(flags_o[5:0])})
        else $error("bit store");
    post_inc_a: assert property (
        take && op_i == `OP_LD_INC && sub_i == 3'h2 |=> ptr_we_o && ptr_sel_o == 2'h2
        && ptr_wdata_o == $past(ptr_z_i) + 16'h0001) else $error("post increment");
    disp_time_a: assert property (
        ldz && !zin |=> !ready_o [*3] ##1 (ready_o || $past(dm_wait_i))) else $error("displacement time");
    sram_extra_a: assert property (
        ldz && zin |=> !ready_o [*4] ##1 (ready_o || $past(dm_wait_i))) else $error("sram time");
endmodule // exec_unit_assertions

// >>> sim/mem_model.sv
// data, program and I/O memories on the far side of the execute unit
// assumes registered strobes and addresses; read data returned at once
`timescale 1ns/1ps
module mem_model (
    input wire mclk_i, // clock
    input wire slow_i, // stretch every data access by one cycle while high
    input wire dm_re_i, // data read
    input wire dm_we_i, // data write
    input wire [15:0] dm_addr_i, // data address
    input wire [7:0] dm_wdata_i, // data value
    input wire [23:0] pm_addr_i, // program byte address
    input wire io_we_i, // io write
    input wire [5:0] io_addr_i, // io address
    input wire [7:0] io_wdata_i, // io value
    output wire [7:0] dm_rdata_o, // data read value
    output wire dm_wait_o, // access not done
    output wire [7:0] pm_rdata_o, // program byte
    output wire [7:0] io_rdata_o // io read value
);
    logic [7:0] dm [0:65535];
    logic [7:0] io [0:63];
    logic waited_q = 1'b0;
    initial for (int i = 0; i < 65536; i++) dm[i] = i[7:0] ^ i[15:8] ^ 8'ha5;
    // idle bus shows inverted data so a stale value never looks valid
    assign dm_rdata_o = dm_re_i ? dm[dm_addr_i] : ~dm[dm_addr_i];
    assign dm_wait_o = slow_i && (dm_re_i || dm_we_i) && !waited_q;
    assign pm_rdata_o = pm_addr_i[7:0] ^ pm_addr_i[23:16] ^ 8'h3c;
    assign io_rdata_o = io[io_addr_i];
    always @(posedge mclk_i) begin
        waited_q <= dm_wait_o;
        if (dm_we_i && !dm_wait_o) dm[dm_addr_i] <= dm_wdata_i;
        if (io_we_i) io[io_addr_i] <= io_wdata_i;
    end
endmodule // mem_model

// >>> sim/tb.sv
// bench: drives the execute unit and compares with an in-bench model
// assumes mem_model and the checker are compiled first
`timescale 1ns/1ps
`include "core_exec_map.vh"
module tb;
    logic mclk_i = 1'b0, resetn_i = 1'b0, issue_i = 1'b0, slow_i = 1'b0, c;
    logic [4:0] op_i = 5'h00, rd_idx_i = 5'h00, o;
    logic [2:0] sub_i = 3'h0, pul, s;
    logic [7:0] rr_i = 8'h00, ext_i = 8'h00, mf = 8'h00, rfd, iow, dwd, r, e;
    logic [15:0] imm_i = 16'h0000, ptr_x_i = 16'h0000, ptr_y_i = 16'h0000, ptr_z_i = 16'h0000;
    logic [15:0] r10_i = 16'h0000, sp_i = 16'h0000, pmw, a, q;
    logic [15:0] p [3];
    logic [16:0] pw;
    logic [23:0] pa;
    wire [7:0] flags_o, rf_wdata_o, dm_wdata_o, io_wdata_o, dm_rdata_i, pm_rdata_i, io_rdata_i;
    wire [15:0] ptr_wdata_o, dm_addr_o, pm_wdata_o, sp_wdata_o;
    wire [23:0] pm_addr_o;
    wire [5:0] io_addr_o;
    wire [4:0] rf_idx_o;
    wire [1:0] ptr_sel_o;
    wire ready_o, rf_we_o, ptr_we_o, sp_we_o, dm_re_o, dm_we_o, pm_re_o, pm_we_o;
    wire io_re_o, io_we_o, break_o, sleep_o, wdog_o, dm_wait_i;
    int n_mismatch = 0, cmp_count = 0, cyc, ticks = 0;
    always #2.5 mclk_i = ~mclk_i;
    exec_unit dut_u (.*);
    mem_model mem_u (.mclk_i(mclk_i), .slow_i(slow_i), .dm_re_i(dm_re_o), .dm_we_i(dm_we_o), .dm_addr_i(dm_addr_o),
        .dm_wdata_i(dm_wdata_o), .pm_addr_i(pm_addr_o), .io_we_i(io_we_o), .io_addr_i(io_addr_o),
        .io_wdata_i(io_wdata_o), .dm_rdata_o(dm_rdata_i), .dm_wait_o(dm_wait_i), .pm_rdata_o(pm_rdata_i),
        .io_rdata_o(io_rdata_i));
    always @(posedge mclk_i) begin
        ticks <= ticks + 1;
        if (ticks == 6000) begin
            n_mismatch++;
            test_done;
        end
    end
    function automatic logic [7:0] pat(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'ha5;
    endfunction
    task chk(input string nm, input logic [23:0] ex, g);
        cmp_count++;
        if (ex !== g) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, ex, g);
        end
    endtask
    // ==========================================
    // one instruction: offer, take, bounded wait for ready
    task run(input logic [4:0] op, input logic [2:0] s, input logic [15:0] im, input logic [7:0] v);
        @(posedge mclk_i);
        {op_i, sub_i, imm_i, rr_i} <= {op, s, im, v};
        rd_idx_i <= 5'($urandom);
        issue_i <= 1'b1;
        {pw, pul, cyc} = '0;
        @(posedge mclk_i);
        issue_i <= 1'b0;
        forever begin
            #1;
            cyc++;
            if (rf_we_o) rfd = rf_wdata_o;
            if (ptr_we_o) pw = {1'b1, ptr_wdata_o};
            if (dm_re_o || dm_we_o) {a, dwd} = {dm_addr_o, dm_wdata_o};
            if (pm_re_o || pm_we_o) {pa, pmw} = {pm_addr_o, pm_wdata_o};
            if (io_we_o) iow = io_wdata_o;
            pul = pul | {break_o, sleep_o, wdog_o};
            if (ready_o || cyc == 30) break;
            @(posedge mclk_i);
        end
    endtask
    task test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h121ea8f2));
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        for (int k = 0; k < 24; k++) begin
            {r, c} = {8'($urandom), 1'($urandom)};
            run(c ? `OP_FLAG_SET : `OP_FLAG_CLR, `FLAG_C, 16'h0, 8'h0);
            run(`OP_SHIFT, 3'(k % 6), 16'h0, r);
            case (k % 6)
                0: {c, e} = {r, 1'b0};
                1: {e, c} = {1'b0, r};
                2: {c, e} = {r, c};
                3: {e, c} = {c, r};
                4: {e, c} = {r[7], r};
                default: e = {r[3:0], r[7:4]};
            endcase
            chk("shift", {c, e}, {flags_o[0], rfd});
        end
        for (int i = 0; i < 24; i++) begin
            run((i / 8) % 2 ? `OP_FLAG_SET : `OP_FLAG_CLR, 3'(i), 16'h0, 8'h0);
            mf[i % 8] = (i / 8) % 2;
            if (i > 6) chk("flags", mf, flags_o);
        end
        for (int i = 0; i < 8; i++) begin
            {r, e} = 16'($urandom);
            run(`OP_BIT_TO_T, 3'(i), 16'h0, r);
            mf[6] = r[i];
            run(`OP_T_TO_BIT, 3'(7 - i), 16'h0, e);
            e[7 - i] = mf[6];
            chk("bit transfer", {mf, e}, {flags_o, rfd});
        end
        // ==========================================
        // data memory: all forms and pointers, in and out of sram
        for (int k = 0; k < 54; k++) begin
            {o, s} = {`OP_LD + 5'(k % 9), 3'(k / 9 % 3)};
            for (int j = 0; j < 3; j++) p[j] = (k < 27 ? 16'h4100 : 16'h2100) + 16'($urandom % 4096);
            {ptr_x_i, ptr_y_i, ptr_z_i} <= {p[0], p[1], p[2]};
            e = o inside {`OP_LD_INC, `OP_ST_INC} ? 8'h01 : o inside {`OP_LD_DEC, `OP_ST_DEC} ? 8'hff : 8'h00;
            pa = o inside {`OP_LD_DISP, `OP_ST_DISP} ? 16'($urandom % 64) : 16'h0;
            q = o == `OP_ST_DIRECT ? p[0] : p[s] + pa[15:0] + {16{e[7]}};
            run(o, s, o == `OP_ST_DIRECT ? q : pa[15:0], pat(q)); // stores write back the pattern
            chk("data address", {pat(q), q}, {o < `OP_ST_DIRECT ? rfd : dwd, a});
            chk("pointer", e ? {1'b1, p[s] + 16'(signed'(e))} : 17'h0, pw);
            if (o < `OP_ST_DIRECT) chk("load cycles", (o < `OP_LD_DEC ? 3 : 4) + (k >= 27), cyc);
        end
        sp_i <= 16'h8123;
        run(`OP_PUSH, 3'h0, 16'h0, 8'h5c);
        chk("push", {8'h01, 8'h5c}, {8'(cyc), dwd});
        run(`OP_POP, 3'h0, 16'h0, 8'h0);
        chk("pop", {8'h04, pat(16'h8124), mf}, {8'(cyc), rfd, flags_o});
        for (int k = 0; k < 6; k++) begin
            {q, a, e} = {16'($urandom), 16'($urandom), 8'($urandom)};
            {r10_i, ptr_z_i, ext_i} <= {q, a, e};
            run(`OP_PM_READ + 5'(k), 3'h2, 16'h0, 8'h0);
            chk("pm address", {k > 1 ? e : 8'h00, a}, pa);
            chk("pm pointer", k % 2 ? {1'b1, a + (k > 3 ? 16'h2 : 16'h1)} : 17'h0, pw);
            if (k < 4) chk("pm read", {8'h05, a[7:0] ^ (k > 1 ? e : 8'h00) ^ 8'h3c}, {8'(cyc), rfd});
            else chk("pm word", q, pmw);
        end
        {q, r} = {16'($urandom % 64), 8'($urandom)};
        run(`OP_IO_OUT, 3'h0, q, r);
        run(`OP_IO_IN, 3'h0, q, 8'h0);
        chk("io move", {r, r}, {iow, rfd});
        for (int i = 0; i < 16; i++) begin
            e = 8'h01 << (i % 8);
            run(i % 2 ? `OP_IO_FLAG_CLEAR_GENERIC : `OP_IO_FLAG_SET_GENERIC, 3'(i), q, 8'h0);
            r = i % 2 ? r & ~e : r | e;
            chk("io bit", {r, mf}, {iow, flags_o});
        end
        for (int k = 0; k < 4; k++) begin
            run(k ? `OP_BREAK + 5'(k - 1) : `OP_NOP, 3'h0, 16'h0, 8'h0);
            chk("control", {3'h4 >> (k ? k - 1 : 3), mf, 8'h01}, {pul, flags_o, 8'(cyc)});
        end
        {slow_i, ptr_x_i} <= {1'b1, 16'h9000};
        run(`OP_LD, 3'h0, 16'h0, 8'h0);
        chk("stretched load", {8'h04, pat(16'h9000)}, {8'(cyc), rfd});
        test_done;
    end
endmodule // tb

bind exec_unit exec_unit_assertions chk_u (.*);
